// >>> core/fsp_defines.svh
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// ------------------------------------------------------------
// word geometry
// ------------------------------------------------------------
`define FSP_WORD_LONG 16
`define FSP_WORD_SHORT 8
`define FSP_CNT_W 4
`define FSP_LAST_LONG 4'hF
`define FSP_LAST_SHORT 4'h7
`define FSP_PULSE_W 5
`define FSP_PULSES_LONG 5'h10
`define FSP_PULSES_SHORT 5'h08

// ------------------------------------------------------------
// serial clock prescalers
// ------------------------------------------------------------
`define FSP_DIV_W 10
`define FSP_PRI_DIV0 10'h040
`define FSP_PRI_DIV1 10'h010
`define FSP_PRI_DIV2 10'h004
`define FSP_PRI_DIV3 10'h001
`define FSP_SEC_BASE 4'h8
`define FSP_DIV_MIN 10'h002

// ------------------------------------------------------------
// link side configuration bits and reset values
// ------------------------------------------------------------
`define FSP_LCFG_W 4
`define FSP_LCFG_FRM 3
`define FSP_LCFG_FSD 2
`define FSP_LCFG_M16 1
`define FSP_LCFG_POL 0
`define FSP_RST_WORD 16'h0000
`define FSP_RST_DIV 10'h000

`endif

// >>> core/fsp_pkg.sv
`include "fsp_defines.svh"
`default_nettype none

package fsp_pkg;

   typedef enum logic [1:0] {FSP_IDLE, FSP_SYNC, FSP_SHIFT} fsp_phase_e;

   // one shift engine
   typedef struct packed {
      fsp_phase_e phase;
      logic [`FSP_CNT_W-1:0] bit_cnt;
      logic [`FSP_WORD_LONG-1:0] sr;
      logic [`FSP_WORD_LONG-1:0] rx_word;
      logic taken_tgl;
      logic done_tgl;
      logic fs_act;
   } fsp_shift_s;

   // link clock domain synchronisers
   typedef struct packed {
      logic [`FSP_LCFG_W-1:0] cfg_s1;
      logic [`FSP_LCFG_W-1:0] cfg_s2;
      logic req_s1;
      logic req_s2;
   } fsp_link_s;

   // instruction clock domain
   typedef struct packed {
      logic role_m;
      logic [`FSP_WORD_LONG-1:0] tx_hold;
      logic req_tgl;
      logic [`FSP_WORD_LONG-1:0] rx_buf;
      logic rbf;
      logic ovf;
      logic evt_flag;
      logic err_flag;
      logic evt_irq;
      logic err_irq;
      logic dma_rx;
      logic dma_tx;
      logic fs_s1;
      logic fs_s2;
      logic sdi_s1;
      logic sdi_s2;
      logic ld_s1;
      logic ld_s2;
      logic ld_seen;
      logic md_seen;
      logic [`FSP_DIV_W-1:0] div_cnt;
      logic sck;
      logic sdo_oe_n;
      logic sck_oe_n;
      logic fs_oe_n;
      logic m_sdo;
      logic m_fs;
   } fsp_sys_s;

   // pin level <-> active state, per frame sync polarity
   function automatic logic fsp_fs_level(input logic lvl, input logic pol);
      return lvl ~^ pol;
   endfunction

endpackage

`default_nettype wire

// >>> core/fsp_shifter.sv
`include "fsp_defines.svh"
`default_nettype none

module fsp_shifter #(
   parameter int WORD_W = `FSP_WORD_LONG
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // timing and configuration
   input wire logic step,
   input wire logic mode16,
   input wire logic fs_wait,
   input wire logic fs_gen,
   input wire logic fs_seen,
   input wire logic sdi,
   // word exchange
   input wire logic req_tgl,
   input wire logic [WORD_W-1:0] tx_word,
   output logic taken_tgl,
   output logic done_tgl,
   output logic [WORD_W-1:0] rx_word,
   output logic tx_bit,
   output logic fs_act,
   output logic busy
);

   fsp_pkg::fsp_shift_s st_reg;
   fsp_pkg::fsp_shift_s st_next;
   logic [WORD_W-1:0] loaded;
   logic [WORD_W-1:0] shifted;
   logic last;

   generate
      if (WORD_W != `FSP_WORD_LONG) begin : g_width_chk
         $error("fsp_shifter serves 16-bit words only");
      end
   endgenerate

   // ------------------------------------------------------------
   // one step per sample edge; the msb leaves on the next transmit edge
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      loaded = mode16 ? tx_word : {tx_word[`FSP_WORD_SHORT-1:0], {`FSP_WORD_SHORT{1'b0}}};
      shifted = {st_reg.sr[WORD_W-2:0], sdi};
      last = st_reg.bit_cnt == (mode16 ? `FSP_LAST_LONG : `FSP_LAST_SHORT);
      if (step) begin
         unique case (st_reg.phase)
            fsp_pkg::FSP_IDLE: begin
               if (fs_wait) begin
                  // a sampled pulse starts a frame with whatever word is held
                  if (fs_seen) begin
                     st_next.sr = loaded;
                     st_next.bit_cnt = '0;
                     st_next.taken_tgl = req_tgl;
                     st_next.phase = fsp_pkg::FSP_SHIFT;
                  end
               end else if (req_tgl != st_reg.taken_tgl) begin
                  st_next.taken_tgl = req_tgl;
                  if (fs_gen) begin
                     st_next.fs_act = 1'b1;
                     st_next.phase = fsp_pkg::FSP_SYNC;
                  end else begin
                     st_next.sr = loaded;
                     st_next.bit_cnt = '0;
                     st_next.phase = fsp_pkg::FSP_SHIFT;
                  end
               end
            end
            fsp_pkg::FSP_SYNC: begin
               // pulse lasts one serial clock, data follows it
               st_next.fs_act = 1'b0;
               st_next.sr = loaded;
               st_next.bit_cnt = '0;
               st_next.phase = fsp_pkg::FSP_SHIFT;
            end
            fsp_pkg::FSP_SHIFT: begin
               st_next.sr = shifted;
               st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
               if (last) begin
                  st_next.rx_word = mode16 ? shifted :
                     {{`FSP_WORD_SHORT{1'b0}}, shifted[`FSP_WORD_SHORT-1:0]};
                  st_next.done_tgl = ~st_reg.done_tgl;
                  st_next.phase = fsp_pkg::FSP_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign taken_tgl = st_reg.taken_tgl;
   assign done_tgl = st_reg.done_tgl;
   assign rx_word = st_reg.rx_word;
   assign tx_bit = st_reg.sr[WORD_W-1];
   assign fs_act = st_reg.fs_act;
   assign busy = st_reg.phase != fsp_pkg::FSP_IDLE;

endmodule

`default_nettype wire

// >>> core/fsp_port.sv
`include "fsp_defines.svh"
`default_nettype none

// Summary of operation
// - master plus frame sync input mode select
// - sampled active sync starts next transmit
// - master sync-input mode flags word completion
// - slave plus frame sync output mode select
// - buffer write drives one-clock sync pulse
// - slave plus frame sync input mode select
// - external master supplies clock and sync
// - output disable releases the data pin
// - unread buffer overflow discards and blocks
// - overflow cleared only by software
// - buffer full sets sticky event flag
// - event request gated by its enable
// - overflow sets sticky error flag, gated
// - master clock from two prescalers
// - unframed pulses match width, framed continuous
// - receive request when word ready
// - transmit request after each completed word
// - slave receive-only requests on first word
// - slave transmit requests after first receive
// - polarity bit sets sync active level
// - clock polarity picks change/sample edges
module fsp_port #(
   parameter int WORD_W = `FSP_WORD_LONG
) (
   // clocks and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic link_clk,
   // configuration
   input wire logic master_role_enable,
   input wire logic framed_enable,
   input wire logic frame_sync_direction,
   input wire logic frame_sync_polarity,
   input wire logic clock_polarity_select,
   input wire logic word_mode16,
   input wire logic output_disable,
   input wire logic [1:0] primary_divider_field,
   input wire logic [2:0] secondary_divider_field,
   input wire logic event_interrupt_enable,
   input wire logic error_interrupt_enable,
   // data buffer
   input wire logic buf_write,
   input wire logic [WORD_W-1:0] buf_wdata,
   input wire logic buf_read,
   output logic [WORD_W-1:0] buf_rdata,
   // flags
   input wire logic overflow_clear,
   input wire logic event_flag_clear,
   input wire logic error_flag_clear,
   output logic receive_buffer_full,
   output logic overflow_flag,
   output logic serial_event_flag,
   output logic error_flag,
   output logic event_irq,
   output logic error_irq,
   // transfer requests
   output logic dma_rx_req,
   output logic dma_tx_req,
   // pins
   input wire logic data_in_pin,
   output logic data_out_pin,
   output logic data_out_oe_n,
   output logic serial_clock_pin,
   output logic serial_clock_oe_n,
   input wire logic frame_sync_in,
   output logic frame_sync_out,
   output logic frame_sync_oe_n
);

   localparam fsp_pkg::fsp_sys_s SYS_RST = '{
      sdo_oe_n: 1'b1,
      sck_oe_n: 1'b1,
      fs_oe_n: 1'b1,
      default: '0
   };

   fsp_pkg::fsp_sys_s st;
   fsp_pkg::fsp_sys_s nx;
   fsp_pkg::fsp_link_s lk;
   fsp_pkg::fsp_link_s lk_next;

   logic [`FSP_DIV_W-1:0] ratio;
   logic [`FSP_DIV_W-1:0] half;
   logic m_run;
   logic tx_pulse;
   logic smp_pulse;
   logic m_step;
   logic m_done_tgl;
   logic m_tx_bit;
   logic m_fs_act;
   logic m_busy;
   logic [WORD_W-1:0] m_rx_word;
   logic l_done_tgl;
   logic l_tx_bit;
   logic l_fs_act;
   logic [WORD_W-1:0] l_rx_word;
   logic l_sdo_reg;
   logic l_fs_reg;
   logic eff_clk;
   logic done_evt;
   logic [WORD_W-1:0] word_in;
   logic fs_in_mode;
   logic [`FSP_PULSE_W-1:0] edge_cnt;

   // ------------------------------------------------------------
   // serial clock ratio
   // ------------------------------------------------------------
   function automatic logic [`FSP_DIV_W-1:0] div_ratio(
      input logic [1:0] pri,
      input logic [2:0] sec
   );
      logic [`FSP_DIV_W-1:0] pr;
      logic [`FSP_DIV_W-1:0] sc;
      logic [`FSP_DIV_W-1:0] prod;
      unique case (pri)
         2'h0: pr = `FSP_PRI_DIV0;
         2'h1: pr = `FSP_PRI_DIV1;
         2'h2: pr = `FSP_PRI_DIV2;
         2'h3: pr = `FSP_PRI_DIV3;
      endcase
      sc = `FSP_DIV_W'(`FSP_SEC_BASE - {1'b0, sec});
      prod = `FSP_DIV_W'(pr * sc);
      // 1:1 overall cannot make two edges per period
      return (prod < `FSP_DIV_MIN) ? `FSP_DIV_MIN : prod;
   endfunction

   assign ratio = div_ratio(primary_divider_field, secondary_divider_field);
   assign half = ratio >> 1;
   // unframed: clock only while a word moves; framed: free running
   assign m_run = master_role_enable & (framed_enable | m_busy);
   assign tx_pulse = m_run & (st.div_cnt == `FSP_RST_DIV);
   assign smp_pulse = m_run & (st.div_cnt == half);
   // unframed idle engine polls every cycle so a write starts at once; framed, it steps on sample pulses only
   assign m_step = master_role_enable & (m_run ? smp_pulse : 1'b1);
   assign fs_in_mode = framed_enable & frame_sync_direction;

   // ------------------------------------------------------------
   // master engine, instruction clock domain
   // ------------------------------------------------------------
   fsp_shifter #(.WORD_W(WORD_W)) u_master (
      .clk(clock),
      .rst(sys_rst),
      .step(m_step),
      .mode16(word_mode16),
      .fs_wait(fs_in_mode),
      .fs_gen(framed_enable & ~frame_sync_direction),
      .fs_seen(fsp_pkg::fsp_fs_level(st.fs_s2, frame_sync_polarity)),
      .sdi(st.sdi_s2),
      .req_tgl(st.req_tgl),
      .tx_word(st.tx_hold),
      .taken_tgl(),
      .done_tgl(m_done_tgl),
      .rx_word(m_rx_word),
      .tx_bit(m_tx_bit),
      .fs_act(m_fs_act),
      .busy(m_busy)
   );

   // ------------------------------------------------------------
   // slave engine, link clock domain
   // ------------------------------------------------------------
   // sample edge of the incoming clock becomes the rising edge here
   assign eff_clk = link_clk ^ ~clock_polarity_select;

   always_comb begin
      lk_next = lk;
      lk_next.cfg_s1 = {framed_enable, frame_sync_direction, word_mode16, frame_sync_polarity};
      lk_next.cfg_s2 = lk.cfg_s1;
      lk_next.req_s1 = st.req_tgl;
      lk_next.req_s2 = lk.req_s1;
   end

   always_ff @(posedge eff_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lk <= '0;
      end else begin
         lk <= lk_next;
      end
   end

   // tx_hold is stable once the request toggle has crossed
   fsp_shifter #(.WORD_W(WORD_W)) u_link (
      .clk(eff_clk),
      .rst(sys_rst),
      .step(1'b1),
      .mode16(lk.cfg_s2[`FSP_LCFG_M16]),
      .fs_wait(lk.cfg_s2[`FSP_LCFG_FRM] & lk.cfg_s2[`FSP_LCFG_FSD]),
      .fs_gen(lk.cfg_s2[`FSP_LCFG_FRM] & ~lk.cfg_s2[`FSP_LCFG_FSD]),
      .fs_seen(fsp_pkg::fsp_fs_level(frame_sync_in, lk.cfg_s2[`FSP_LCFG_POL])),
      .sdi(data_in_pin),
      .req_tgl(lk.req_s2),
      .tx_word(st.tx_hold),
      .taken_tgl(),
      .done_tgl(l_done_tgl),
      .rx_word(l_rx_word),
      .tx_bit(l_tx_bit),
      .fs_act(l_fs_act),
      .busy()
   );

   // outputs change on the transmit edge, half a clock after sampling
   always_ff @(negedge eff_clk or posedge sys_rst) begin
      if (sys_rst) begin
         l_sdo_reg <= 1'b0;
         l_fs_reg <= 1'b0;
      end else begin
         l_sdo_reg <= l_tx_bit;
         l_fs_reg <= fsp_pkg::fsp_fs_level(l_fs_act, lk.cfg_s2[`FSP_LCFG_POL]);
      end
   end

   // ------------------------------------------------------------
   // buffer, flags and requests, instruction clock domain
   // ------------------------------------------------------------
   assign done_evt = st.role_m ? (m_done_tgl != st.md_seen) : (st.ld_s2 != st.ld_seen);
   assign word_in = st.role_m ? m_rx_word : l_rx_word;

   always_comb begin
      nx = st;
      nx.role_m = master_role_enable;
      nx.fs_s1 = frame_sync_in;
      nx.fs_s2 = st.fs_s1;
      nx.sdi_s1 = data_in_pin;
      nx.sdi_s2 = st.sdi_s1;
      nx.ld_s1 = l_done_tgl;
      nx.ld_s2 = st.ld_s1;
      nx.ld_seen = st.ld_s2;
      nx.md_seen = m_done_tgl;
      if (buf_write) begin
         nx.tx_hold = buf_wdata;
         nx.req_tgl = ~st.req_tgl;
      end
      if (buf_read) begin
         nx.rbf = 1'b0;
      end
      if (overflow_clear) begin
         nx.ovf = 1'b0;
      end
      if (done_evt) begin
         if (st.rbf || st.ovf) begin
            // word dropped; overflow set wins over a same-cycle clear
            if (st.rbf) begin
               nx.ovf = 1'b1;
            end
         end else begin
            nx.rx_buf = word_in;
            nx.rbf = 1'b1;
         end
      end
      // first request only once a word has really moved
      nx.dma_rx = nx.rbf & ~st.rbf;
      nx.dma_tx = done_evt;
      if (event_flag_clear) begin
         nx.evt_flag = 1'b0;
      end
      if ((nx.rbf & ~st.rbf) | (done_evt & st.role_m & fs_in_mode)) begin
         nx.evt_flag = 1'b1;
      end
      if (error_flag_clear) begin
         nx.err_flag = 1'b0;
      end
      if (nx.ovf & ~st.ovf) begin
         nx.err_flag = 1'b1;
      end
      nx.evt_irq = nx.evt_flag & event_interrupt_enable;
      nx.err_irq = nx.err_flag & error_interrupt_enable;
      // prescaler and master clock pin
      if (!m_run || st.div_cnt == ratio - 1'b1) begin
         nx.div_cnt = `FSP_RST_DIV;
      end else begin
         nx.div_cnt = st.div_cnt + 1'b1;
      end
      if (tx_pulse) begin
         nx.sck = ~clock_polarity_select;
         nx.m_sdo = m_tx_bit;
         nx.m_fs = fsp_pkg::fsp_fs_level(m_fs_act, frame_sync_polarity);
      end else if (smp_pulse || !m_run) begin
         nx.sck = clock_polarity_select;
      end
      nx.sdo_oe_n = output_disable;
      nx.sck_oe_n = ~master_role_enable;
      nx.fs_oe_n = ~(framed_enable & ~frame_sync_direction);
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st <= SYS_RST;
      end else begin
         st <= nx;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign buf_rdata = st.rx_buf;
   assign receive_buffer_full = st.rbf;
   assign overflow_flag = st.ovf;
   assign serial_event_flag = st.evt_flag;
   assign error_flag = st.err_flag;
   assign event_irq = st.evt_irq;
   assign error_irq = st.err_irq;
   assign dma_rx_req = st.dma_rx;
   assign dma_tx_req = st.dma_tx;
   assign serial_clock_pin = st.sck;
   assign serial_clock_oe_n = st.sck_oe_n;
   assign frame_sync_oe_n = st.fs_oe_n;
   // role is static in use; the pin picks the flop of the active domain
   assign data_out_pin = st.role_m ? st.m_sdo : l_sdo_reg;
   assign frame_sync_out = st.role_m ? st.m_fs : l_fs_reg;
   assign data_out_oe_n = st.sdo_oe_n;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         edge_cnt <= '0;
      end else if (tx_pulse && m_busy) begin
         edge_cnt <= edge_cnt + 1'b1;
      end else if (!m_busy) begin
         edge_cnt <= '0;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   sequence s_overrun;
      done_evt && st.rbf && !st.ovf;
   endsequence

   sequence s_flagged;
      st.ovf && st.err_flag;
   endsequence

   sequence s_fs_hit;
      master_role_enable && fs_in_mode && smp_pulse && !m_busy &&
         fsp_pkg::fsp_fs_level(st.fs_s2, frame_sync_polarity);
   endsequence

   overrun_drop_a: assert property (s_overrun |=> s_flagged ##0 $stable(st.rx_buf))
      else $error("overrun did not set flags or kept the new word");
   overflow_hold_a: assert property (st.ovf && !overflow_clear |=> st.ovf)
      else $error("overflow flag cleared without software");
   event_on_full_a: assert property ($rose(st.rbf) |-> st.evt_flag)
      else $error("buffer full did not set event flag");
   event_gate_a: assert property (!event_interrupt_enable |=> !event_irq)
      else $error("event request raised while disabled");
   error_follow_a: assert property ($rose(st.ovf) |-> st.err_flag ##1
      (error_irq == (st.err_flag && $past(error_interrupt_enable))))
      else $error("error flag or request wrong after overflow");
   rx_request_a: assert property ($rose(st.rbf) |-> dma_rx_req ##1 !dma_rx_req)
      else $error("receive request not a single pulse");
   tx_request_a: assert property (done_evt |=> dma_tx_req)
      else $error("no transmit request after completed word");
   sdo_release_a: assert property (output_disable |=> data_out_oe_n)
      else $error("data pin still driven while disabled");
   pulse_count_a: assert property ($fell(m_busy) && master_role_enable && !framed_enable
      |-> edge_cnt == (word_mode16 ? `FSP_PULSES_LONG : `FSP_PULSES_SHORT))
      else $error("unframed word sent wrong number of clock pulses");
   fs_start_a: assert property (s_fs_hit |=> m_busy ##1 !tx_pulse [*1])
      else $error("sampled frame sync did not start a word");
   fs_in_event_a: assert property (done_evt && st.role_m && fs_in_mode
      |=> serial_event_flag)
      else $error("completion in sync-input master mode not flagged");
   mode_m_fsin_a: assert property (master_role_enable && fs_in_mode
      |=> frame_sync_oe_n && !serial_clock_oe_n)
      else $error("master sync-input mode pin directions wrong");
   mode_s_fsout_a: assert property (!master_role_enable && framed_enable
      && !frame_sync_direction |=> !frame_sync_oe_n && serial_clock_oe_n)
      else $error("slave sync-output mode pin directions wrong");
   mode_s_fsin_a: assert property (!master_role_enable && fs_in_mode
      |=> frame_sync_oe_n && serial_clock_oe_n)
      else $error("slave sync-input mode pin directions wrong");

endmodule

`default_nettype wire

// >>> tb/fsp_far_end.sv
`default_nettype none

// -----------------------------------------
// far-side peripheral, clock polarity zero
// -----------------------------------------
module fsp_far_end (
   // serial side
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   // test control
   input wire logic arm,
   input wire logic [15:0] word,
   input wire logic [4:0] nbits,
   output logic [15:0] got,
   output logic [4:0] edges
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] sh;
   logic bitq = 1'b0;
   logic idle = 1'b1;
   // once the word is over the line shows the inverse, so a late sample cannot match by luck
   assign miso = idle ? ~bitq : bitq;
   always @(posedge sck or posedge arm) begin
      if (arm) begin
         sh <= word;
      end else begin
         bitq <= sh[15];
         sh <= sh << 1;
      end
   end
   always @(negedge sck or posedge arm) begin
      if (arm) begin
         got <= 16'h0000;
         edges <= 5'h00;
         idle <= 1'b0;
      end else begin
         got <= {got[14:0], mosi};
         edges <= edges + 5'h01;
         idle <= (edges + 5'h01 == nbits);
      end
   end
endmodule

`default_nettype wire

// >>> tb/tb.sv
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic m16;
      logic [1:0] pp;
      logic [2:0] sp;
      logic [15:0] tx;
      logic [15:0] far;
      logic [15:0] rx;
      logic [4:0] n;
      logic [7:0] per;
   } fsp_row_s;
   localparam fsp_row_s ROWS [3] = '{
      '{1'b1, 2'h3, 3'h0, 16'hA5C3, 16'h3C5A, 16'h3C5A, 5'h10, 8'h08},
      '{1'b0, 2'h2, 3'h6, 16'h0081, 16'h7E00, 16'h007E, 5'h08, 8'h08},
      '{1'b1, 2'h3, 3'h2, 16'hFFFF, 16'h0001, 16'h0001, 5'h10, 8'h06}};
   logic clock = 1'b0, sys_rst = 1'b1, link_clk = 1'b0;
   logic master_role_enable = 1'b1, framed_enable = 1'b0, frame_sync_direction = 1'b0;
   logic frame_sync_polarity = 1'b1, clock_polarity_select = 1'b0, word_mode16 = 1'b1;
   logic output_disable = 1'b0, event_interrupt_enable = 1'b1, error_interrupt_enable = 1'b0;
   logic [1:0] primary_divider_field = 2'h3;
   logic [2:0] secondary_divider_field = 3'h0;
   logic buf_write = 1'b0, buf_read = 1'b0, overflow_clear = 1'b0, far_arm = 1'b0;
   logic event_flag_clear = 1'b0, error_flag_clear = 1'b0, frame_sync_in = 1'b0;
   logic [15:0] buf_wdata = 16'h0000, buf_rdata, far_word = 16'h0000, far_got;
   logic receive_buffer_full, overflow_flag, serial_event_flag, error_flag, event_irq;
   logic error_irq, dma_rx_req, dma_tx_req, data_in_pin, data_out_pin, data_out_oe_n;
   logic serial_clock_pin, serial_clock_oe_n, frame_sync_out, frame_sync_oe_n;
   logic [4:0] far_edges, far_n = 5'h10;
   int n_fail = 0, cmp_count = 0, cyc = 0, sck_n = 0;
   time t0;
   wire [3:0] watch = {dma_rx_req, serial_event_flag, overflow_flag, receive_buffer_full};

   fsp_port i_dut (.clock, .sys_rst, .link_clk, .master_role_enable, .framed_enable,
      .frame_sync_direction, .frame_sync_polarity, .clock_polarity_select, .word_mode16,
      .output_disable, .primary_divider_field, .secondary_divider_field,
      .event_interrupt_enable, .error_interrupt_enable, .buf_write, .buf_wdata, .buf_read,
      .buf_rdata, .overflow_clear, .event_flag_clear, .error_flag_clear, .receive_buffer_full,
      .overflow_flag, .serial_event_flag, .error_flag, .event_irq, .error_irq, .dma_rx_req,
      .dma_tx_req, .data_in_pin, .data_out_pin, .data_out_oe_n, .serial_clock_pin,
      .serial_clock_oe_n, .frame_sync_in, .frame_sync_out, .frame_sync_oe_n);
   fsp_far_end i_far (.sck(serial_clock_pin), .mosi(data_out_pin), .miso(data_in_pin),
      .arm(far_arm), .word(far_word), .nbits(far_n), .got(far_got), .edges(far_edges));

   // --------------------------------
   // clocks, hang guard and helpers
   // --------------------------------
   always #50 clock = ~clock;
   always #80 link_clk = ~link_clk;
   always @(posedge serial_clock_pin) sck_n++;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wait_hi(input int k);
      for (int i = 0; i < 600 && watch[k] !== 1'b1; i++) @(negedge clock);
   endtask
   task automatic wr(input logic [15:0] w);
      {far_arm, buf_write} <= 2'h3;
      buf_wdata <= w;
      tk(1);
      {far_arm, buf_write} <= 2'h0;
   endtask
   task automatic clr;
      {buf_read, overflow_clear, event_flag_clear, error_flag_clear} <= 4'hF;
      tk(1);
      {buf_read, overflow_clear, event_flag_clear, error_flag_clear} <= 4'h0;
   endtask
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      tk(2);
      sys_rst <= 1'b0;
      @(negedge clock);
      chk({receive_buffer_full, overflow_flag, serial_event_flag, error_flag}, 16'h0000);
      tk(1);
      foreach (ROWS[i]) begin
         word_mode16 <= ROWS[i].m16;
         primary_divider_field <= ROWS[i].pp;
         secondary_divider_field <= ROWS[i].sp;
         far_word <= ROWS[i].far;
         far_n <= ROWS[i].n;
         tk(1);
         wr(ROWS[i].tx);
         @(posedge serial_clock_pin);
         t0 = $time;
         @(posedge serial_clock_pin);
         chk(16'(($time - t0) / 100), 16'(ROWS[i].per));
         wait_hi(0);
         chk({dma_rx_req, dma_tx_req, serial_event_flag}, 16'h0007);
         @(negedge clock);
         chk(event_irq, 1'b1);
         chk(buf_rdata, ROWS[i].rx);
         chk(far_got, ROWS[i].m16 ? ROWS[i].tx : {8'h00, ROWS[i].tx[7:0]});
         chk(16'(far_edges), 16'(ROWS[i].n));
         tk(1);
         clr();
      end
      event_interrupt_enable <= 1'b0;
      wr(16'h1234);
      wait_hi(0);
      tk(1);
      far_word <= 16'hBEEF;
      wr(16'h5678);
      wait_hi(1);
      tk(2);
      @(negedge clock);
      chk({overflow_flag, error_flag, error_irq, event_irq}, 16'h000C);
      chk(buf_rdata, 16'h0001);
      tk(1);
      error_interrupt_enable <= 1'b1;
      output_disable <= 1'b1;
      tk(40);
      @(negedge clock);
      chk({overflow_flag, error_irq, data_out_oe_n}, 16'h0007);
      tk(1);
      clr();
      output_disable <= 1'b0;
      framed_enable <= 1'b1;
      frame_sync_direction <= 1'b1;
      tk(2);
      wr(16'hC0DE);
      sck_n = 0;
      tk(40);
      @(negedge clock);
      chk({serial_clock_oe_n, frame_sync_oe_n}, 16'h0001);
      chk(16'(sck_n > 3), 16'h0001);
      tk(1);
      frame_sync_in <= 1'b1;
      tk(12);
      frame_sync_in <= 1'b0;
      wait_hi(2);
      chk(serial_event_flag, 1'b1);
      tk(1);
      clr();
      master_role_enable <= 1'b0;
      frame_sync_direction <= 1'b0;
      frame_sync_polarity <= 1'b0;
      tk(8);
      @(negedge clock);
      chk({serial_clock_oe_n, frame_sync_oe_n, frame_sync_out}, 16'h0005);
      tk(1);
      frame_sync_polarity <= 1'b1;
      tk(8);
      wr(16'h9A3C);
      @(posedge frame_sync_out);
      t0 = $time;
      #1 chk(link_clk, 1'b1);
      @(negedge frame_sync_out);
      chk(16'($time - t0), 16'h00A0);
      wait_hi(0);
      tk(1);
      clr();
      frame_sync_direction <= 1'b1;
      tk(8);
      @(negedge clock);
      chk({serial_clock_oe_n, frame_sync_oe_n}, 16'h0003);
      tk(1);
      frame_sync_in <= 1'b1;
      tk(4);
      frame_sync_in <= 1'b0;
      wait_hi(3);
      chk({dma_rx_req, dma_tx_req}, 16'h0003);
      give_verdict();
   end
endmodule

`default_nettype wire
